// ---- maintenance_hours_counter_tb.sv ----
// self-checking bench for the maintenance hours counter
`timescale 1ns/10ps
module maintenance_hours_counter_tb;
	logic                  hclk, hresetn, hsel, hwrite, ce;
	logic [31:0]           haddr, hwdata, hrdata;
	logic [1:0]            htrans;
	wire logic             hreadyout, hresp, alarm_output, irq;
	mhc_pkg::mhc_pins_type pins;
	mhc_pkg::mhc_hm_type   live;
	int                    err_total, n_tests;

	mhc_top #(.MINUTE_TICKS(33'h4)) dut_u (.hclk(hclk), .hresetn(hresetn),
		.ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
		.live_interval(live), .alarm_output(alarm_output), .irq(irq));

	//////////////////////////////////////////////////////////////
	function automatic logic [31:0] hm(input int h, input int m);
		return {2'h0, 6'(m), 7'h0, 17'(h)};
	endfunction
	task automatic chk(input string s, input logic [31:0] e, g);
		n_tests++;
		if (g !== e)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	// master waits on hready as long as it takes; only the watchdog ends it
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, string s);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(s, e, x);
	endtask
	task automatic pulse(input bit full);
		if (full)
			pins.full_clear <= 1'b1;
		else
			pins.interval_restart <= 1'b1;
		@(posedge hclk);
		pins.full_clear <= 1'b0;
		pins.interval_restart <= 1'b0;
		@(posedge hclk);
	endtask
	task automatic mon(input int n);
		pins.monitor_en <= 1'b1;
		repeat (n) @(posedge hclk);
		pins.monitor_en <= 1'b0;
		@(posedge hclk);
	endtask
	task automatic end_sim();
		$display("errors %0d checks %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	//////////////////////////////////////////////////////////////
	initial
	begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	initial
	begin
		#20000;
		err_total++;
		end_sim();
	end
	initial
	begin
		{hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
		ce = 1'b1;
		pins = '0;
		live = '{17'h00007, 6'h05};
		{err_total, n_tests} = '0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rc(mhc_pkg::ADDR_MASK, 32'h0, "mask");
		rc(mhc_pkg::ADDR_CTRL, 32'h0, "ctrl");
		wr(8'h1c, 32'hffffffff);
		rc(8'h1c, 32'h0, "unmapped");
		wr(mhc_pkg::ADDR_INTERVAL, hm(65535, 63));
		rc(mhc_pkg::ADDR_INTERVAL, hm(9999, 59), "clamp");
		wr(mhc_pkg::ADDR_INTERVAL, hm(0, 3));
		wr(mhc_pkg::ADDR_RUN, hm(1, 0));
		pulse(1);
		rc(mhc_pkg::ADDR_RUN, 32'h0, "run zero");
		rc(mhc_pkg::ADDR_TOGO, hm(0, 3), "togo load");
		chk("alarm clr", 32'h0, {31'h0, alarm_output});
		mon(8);
		rc(mhc_pkg::ADDR_RUN, hm(0, 2), "run count");
		rc(mhc_pkg::ADDR_TOGO, hm(0, 1), "togo count");
		pulse(0);
		rc(mhc_pkg::ADDR_TOGO, hm(0, 3), "togo reload");
		rc(mhc_pkg::ADDR_RUN, hm(0, 2), "run kept");
		// a low enable must freeze the minute base and both counters
		ce <= 1'b0;
		mon(8);
		ce <= 1'b1;
		rc(mhc_pkg::ADDR_RUN, hm(0, 2), "run frozen");
		// the alarm rose once after reset; clear that before the real test
		wr(mhc_pkg::ADDR_STATUS, 32'h3);
		rc(mhc_pkg::ADDR_STATUS, 32'h0, "status clr");
		wr(mhc_pkg::ADDR_MASK, 32'h1);
		mon(16);
		rc(mhc_pkg::ADDR_TOGO, 32'h0, "togo floor");
		rc(mhc_pkg::ADDR_RUN, hm(0, 6), "run on");
		chk("alarm set", 32'h1, {31'h0, alarm_output});
		chk("irq set", 32'h1, {31'h0, irq});
		rc(mhc_pkg::ADDR_STATUS, 32'h1, "status");
		rc(mhc_pkg::ADDR_PINS, 32'h2, "pins");
		wr(mhc_pkg::ADDR_STATUS, 32'h1);
		repeat (2) @(posedge hclk);
		chk("irq clr", 32'h0, {31'h0, irq});
		chk("alarm held", 32'h1, {31'h0, alarm_output});
		wr(mhc_pkg::ADDR_CTRL, 32'h1);
		repeat (2) @(posedge hclk);
		chk("alarm mon", 32'h0, {31'h0, alarm_output});
		wr(mhc_pkg::ADDR_RUN, hm(99998, 59));
		mon(12);
		rc(mhc_pkg::ADDR_RUN, hm(99999, 0), "run sat");
		rc(mhc_pkg::ADDR_STATUS, 32'h3, "sat flag");
		wr(mhc_pkg::ADDR_CTRL, 32'h2);
		pulse(0);
		rc(mhc_pkg::ADDR_TOGO, hm(7, 5), "live");
		end_sim();
	end
endmodule

bind mhc_top mhc_checker chk_u (.hclk(hclk), .hresetn(hresetn), .ce(ce),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
	.alarm_output(alarm_output));

// ---- mhc_checker.sv ----
// port checker for the maintenance hours counter
`timescale 1ns/10ps
module mhc_checker
(
	// clock, reset, enable
	input wire logic                  hclk,
	input wire logic                  hresetn,
	input wire logic                  ce,
	// bus
	input wire logic                  hsel,
	input wire logic [1:0]            htrans,
	input wire logic                  hwrite,
	input wire logic                  hready,
	input wire logic [31:0]           hrdata,
	input wire logic                  hreadyout,
	input wire logic                  hresp,
	// pins
	input wire mhc_pkg::mhc_pins_type pins,
	input wire logic                  alarm_output
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	mhc_pkg::mhc_pins_type prev_q;
	wire rr = pins.interval_restart & ~prev_q.interval_restart;
	wire rf = pins.full_clear & ~prev_q.full_clear;
	wire rd = hsel & htrans[1] & hready & ~hwrite & ce;
	// edge history mirrors the block's own, reset to zero
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			prev_q <= '0;
		else if (ce)
			prev_q <= pins;
	//////////////////////////////////////////////////////////////
	chk_ready_high: assert property (hreadyout)
		else $error("hreadyout low");
	chk_resp_okay: assert property (!hresp)
		else $error("hresp not okay");
	chk_rdata_idle: assert property ($past(ce) && !$past(rd)
		|-> hrdata == 32'h0)
		else $error("hrdata outside read");
	chk_restart_clr: assert property (ce && rr |=> !alarm_output)
		else $error("restart did not clear alarm");
	chk_full_clr: assert property (ce && rf |=> !alarm_output)
		else $error("full clear did not clear alarm");
	chk_alarm_keep: assert property (ce && alarm_output && pins.monitor_en
		&& !rr && !rf |=> alarm_output)
		else $error("alarm dropped without cause");
	chk_alarm_rise: assert property ($rose(alarm_output) |-> !$past(rr || rf))
		else $error("alarm set against clear edge");
	chk_fall_cause: assert property ($fell(alarm_output)
		|-> $past(rr || rf || !pins.monitor_en))
		else $error("alarm fell without cause");
endmodule

// ---- mhc_hm_count.sv ----
// hours and minutes counter, up with saturation or down to zero
`timescale 1ns/10ps
module mhc_hm_count
#(
	parameter bit          UP        = 1'b1,
	parameter logic [16:0] HOURS_MAX = mhc_pkg::RUN_HOURS_MAX
)
(
	// clock and reset
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               ce,
	// control
	input  wire logic               load,
	input  wire mhc_pkg::mhc_hm_type load_val,
	input  wire logic               step,
	// state
	output      mhc_pkg::mhc_hm_type value,
	output      logic               at_limit
);
	mhc_pkg::mhc_hm_type val_q;
	mhc_pkg::mhc_hm_type inc;
	mhc_pkg::mhc_hm_type dec;
	logic                min_top;
	logic                min_zero;

	assign min_top  = (val_q.minutes == mhc_pkg::MINUTES_MAX);
	assign min_zero = (val_q.minutes == 6'h00);
	assign inc.hours   = min_top ? val_q.hours + 1'b1 : val_q.hours;
	assign inc.minutes = min_top ? 6'h00 : val_q.minutes + 1'b1;
	assign dec.hours   = min_zero ? val_q.hours - 1'b1 : val_q.hours;
	assign dec.minutes = min_zero ? mhc_pkg::MINUTES_MAX
		: val_q.minutes - 1'b1;
	// up stops at the hour limit, down never wraps below zero
	assign at_limit = UP ? (val_q.hours >= HOURS_MAX) // RULE8
		: (val_q == mhc_pkg::HM_ZERO); // RULE12
	assign value = val_q;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			val_q <= mhc_pkg::HM_ZERO;
		else if (ce && load)
			val_q <= load_val;
		else if (ce && step && !at_limit)
			val_q <= UP ? inc : dec;
	end
endmodule

// ---- mhc_pkg.sv ----
// package for the maintenance hours counter: map, fields, timing
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RULE1: restart edge clears alarm, reloads time to go
// RULE2: full clear edge also zeroes run time
// RULE3: monitor high advances run, decreases time to go
// RULE4: alarm high once time to go is zero
// RULE5: config bit adds monitor low as clear
// RULE6: interval is hours 0..9999, minutes 0..59
// RULE7: run time to 99999 h, presettable offset
// RULE8: run time saturates at its upper limit
// RULE9: run time ignores the restart input
// RULE10: interval, time to go, run time retained
// RULE11: interval from register or live input
// RULE12: time to go stops at zero; minute tick
//////////////////////////////////////////////////////////////////////////////
package mhc_pkg;

	typedef struct packed
	{
		logic [16:0] hours;
		logic [5:0]  minutes;
	} mhc_hm_type;

	// register byte offsets
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_INTERVAL = 8'h04;
	localparam logic [7:0] ADDR_RUN      = 8'h08;
	localparam logic [7:0] ADDR_TOGO     = 8'h0c;
	localparam logic [7:0] ADDR_STATUS   = 8'h10;
	localparam logic [7:0] ADDR_MASK     = 8'h14;
	localparam logic [7:0] ADDR_PINS     = 8'h18;

	// field positions
	localparam int HOURS_LSB   = 0;
	localparam int MINUTES_LSB = 24;
	localparam int CTRL_CLR_EN = 0;
	localparam int CTRL_LIVE   = 1;
	localparam int EV_ALARM    = 0;
	localparam int EV_SAT      = 1;
	localparam int EV_W        = 2;
	localparam int PIN_MON     = 0;
	localparam int PIN_ALARM   = 1;

	// limits
	localparam logic [16:0] INTERVAL_HOURS_MAX = 17'h0270f;
	localparam logic [16:0] RUN_HOURS_MAX      = 17'h1869f;
	localparam logic [5:0]  MINUTES_MAX        = 6'h3b;

	// reset values
	localparam logic [1:0]       CTRL_RESET = 2'h0;
	localparam logic [EV_W-1:0]  MASK_RESET = 2'h0;
	localparam mhc_hm_type       HM_ZERO    = '{17'h00000, 6'h00};

	// timing
	localparam longint CLK_PERIOD_NS = 8;
	localparam longint MINUTE_NS     = 60_000_000_000;
	localparam longint MINUTE_CYCLES = MINUTE_NS / CLK_PERIOD_NS;
	localparam int     TICK_W        = 33;

	typedef struct packed
	{
		logic monitor_en;
		logic interval_restart;
		logic full_clear;
	} mhc_pins_type;

endpackage

// ---- mhc_tick.sv ----
// minute time base counting monitored on-time
`timescale 1ns/10ps
module mhc_tick
#(
	parameter logic [mhc_pkg::TICK_W-1:0] PERIOD =
		mhc_pkg::TICK_W'(mhc_pkg::MINUTE_CYCLES)
)
(
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic ce,
	// control
	input  wire logic run,
	output      logic tick
);
	logic [mhc_pkg::TICK_W-1:0] cnt_q;
	logic [mhc_pkg::TICK_W-1:0] cnt_d;
	logic                       wrap;

	// partial minutes are kept while the monitor is low
	assign wrap  = (cnt_q == PERIOD - 1'b1);
	assign cnt_d = wrap ? '0 : cnt_q + 1'b1;
	assign tick  = ce && run && wrap; // RULE12

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cnt_q <= '0;
		else if (ce && run)
			cnt_q <= cnt_d;
	end
endmodule

// ---- mhc_top.sv ----
// maintenance hours counter with ahb-lite register slave
`timescale 1ns/10ps
module mhc_top
#(
	parameter logic [mhc_pkg::TICK_W-1:0] MINUTE_TICKS =
		mhc_pkg::TICK_W'(mhc_pkg::MINUTE_CYCLES)
)
(
	// clock, reset, enable
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                ce,
	// ahb-lite slave
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output      logic [31:0]         hrdata,
	output      logic                hreadyout,
	output      logic                hresp,
	// function block pins
	input  wire mhc_pkg::mhc_pins_type pins,
	input  wire mhc_pkg::mhc_hm_type  live_interval,
	output      logic                alarm_output,
	output      logic                irq
);
	//////////////////////////////////////////////////////////////////////////
	// bus address phase capture

	logic       wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] rdata_q;
	logic        hready_q;
	logic        addr_ok;
	logic [31:0] rd_mux;

	assign addr_ok = hsel && htrans[1] && hready;

	//////////////////////////////////////////////////////////////////////////
	// software registers

	logic [1:0]              ctrl_q;
	mhc_pkg::mhc_hm_type     interval_q;
	logic [mhc_pkg::EV_W-1:0] status_q;
	logic [mhc_pkg::EV_W-1:0] status_d;
	logic [mhc_pkg::EV_W-1:0] mask_q;
	logic [mhc_pkg::EV_W-1:0] ev;
	logic [mhc_pkg::EV_W-1:0] w1c;

	wire wr_ctrl = wr_pend_q && wr_addr_q == mhc_pkg::ADDR_CTRL;
	wire wr_intv = wr_pend_q && wr_addr_q == mhc_pkg::ADDR_INTERVAL;
	wire wr_run  = wr_pend_q && wr_addr_q == mhc_pkg::ADDR_RUN;
	wire wr_stat = wr_pend_q && wr_addr_q == mhc_pkg::ADDR_STATUS;
	wire wr_mask = wr_pend_q && wr_addr_q == mhc_pkg::ADDR_MASK;

	// written time fields clamp to their legal range
	wire [16:0] wh = hwdata[mhc_pkg::HOURS_LSB +: 17];
	wire [5:0]  wm = hwdata[mhc_pkg::MINUTES_LSB +: 6];
	mhc_pkg::mhc_hm_type intv_wr;
	mhc_pkg::mhc_hm_type run_wr;
	assign intv_wr.hours = (wh > mhc_pkg::INTERVAL_HOURS_MAX)
		? mhc_pkg::INTERVAL_HOURS_MAX : wh; // RULE6
	assign intv_wr.minutes = (wm > mhc_pkg::MINUTES_MAX)
		? mhc_pkg::MINUTES_MAX : wm; // RULE6
	assign run_wr.hours = (wh > mhc_pkg::RUN_HOURS_MAX)
		? mhc_pkg::RUN_HOURS_MAX : wh; // RULE7
	assign run_wr.minutes = (wm > mhc_pkg::MINUTES_MAX)
		? mhc_pkg::MINUTES_MAX : wm; // RULE7

	//////////////////////////////////////////////////////////////////////////
	// pin edges and interval source

	logic restart_prev_q;
	logic clear_prev_q;
	logic alarm_q;
	logic alarm_d;
	wire  mon = pins.monitor_en;
	wire  restart_edge = pins.interval_restart && !restart_prev_q;
	wire  clear_edge   = pins.full_clear && !clear_prev_q;

	// live source is clamped too so a wide upstream value cannot overflow
	mhc_pkg::mhc_hm_type live_cl;
	mhc_pkg::mhc_hm_type interval_eff;
	assign live_cl.hours = (live_interval.hours > mhc_pkg::INTERVAL_HOURS_MAX)
		? mhc_pkg::INTERVAL_HOURS_MAX : live_interval.hours;
	assign live_cl.minutes = (live_interval.minutes > mhc_pkg::MINUTES_MAX)
		? mhc_pkg::MINUTES_MAX : live_interval.minutes;
	assign interval_eff = ctrl_q[mhc_pkg::CTRL_LIVE]
		? live_cl : interval_q; // RULE11

	//////////////////////////////////////////////////////////////////////////
	// counters

	logic                tick;
	mhc_pkg::mhc_hm_type run_val;
	mhc_pkg::mhc_hm_type togo_val;
	logic                run_sat;
	logic                togo_zero;
	logic                run_sat_prev_q;
	logic                run_load;
	mhc_pkg::mhc_hm_type run_load_val;
	wire                 togo_load = restart_edge || clear_edge; // RULE1 RULE2

	// a full clear beats a software preset landing in the same cycle
	assign run_load     = clear_edge || wr_run; // RULE7
	assign run_load_val = clear_edge ? mhc_pkg::HM_ZERO : run_wr; // RULE2

	mhc_tick
	#(
		.PERIOD (MINUTE_TICKS)
	)
	u_tick
	(
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.run     (mon), // RULE3
		.tick    (tick)
	);

	// run time advances on ticks regardless of the restart input
	mhc_hm_count
	#(
		.UP        (1'b1),
		.HOURS_MAX (mhc_pkg::RUN_HOURS_MAX)
	)
	u_run
	(
		.hclk     (hclk),
		.hresetn  (hresetn),
		.ce       (ce),
		.load     (run_load),
		.load_val (run_load_val),
		.step     (tick), // RULE3 RULE9
		.value    (run_val),
		.at_limit (run_sat)
	);

	mhc_hm_count
	#(
		.UP        (1'b0),
		.HOURS_MAX (mhc_pkg::INTERVAL_HOURS_MAX)
	)
	u_togo
	(
		.hclk     (hclk),
		.hresetn  (hresetn),
		.ce       (ce),
		.load     (togo_load),
		.load_val (interval_eff), // RULE1 RULE2
		.step     (tick), // RULE3
		.value    (togo_val),
		.at_limit (togo_zero)
	);

	//////////////////////////////////////////////////////////////////////////
	// alarm

	// clear edges win this cycle; a zero interval re-raises next cycle
	wire alarm_clr = restart_edge || clear_edge
		|| (ctrl_q[mhc_pkg::CTRL_CLR_EN] && !mon); // RULE1 RULE2 RULE5
	assign alarm_d = alarm_clr ? 1'b0 : (alarm_q || togo_zero); // RULE4

	//////////////////////////////////////////////////////////////////////////
	// interrupt status

	assign ev[mhc_pkg::EV_ALARM] = alarm_d && !alarm_q;
	assign ev[mhc_pkg::EV_SAT]   = run_sat && !run_sat_prev_q;
	assign w1c      = wr_stat ? hwdata[mhc_pkg::EV_W-1:0] : '0;
	// a new event outweighs a clear in the same cycle
	assign status_d = (status_q & ~w1c) | ev;

	//////////////////////////////////////////////////////////////////////////
	// read mux

	function automatic logic [31:0] hm_word(input mhc_pkg::mhc_hm_type v);
		logic [31:0] w;
		w = '0;
		w[mhc_pkg::HOURS_LSB +: 17]  = v.hours;
		w[mhc_pkg::MINUTES_LSB +: 6] = v.minutes;
		return w;
	endfunction

	wire [7:0] raddr = haddr[7:0];
	wire       in_map = haddr[31:8] == 24'h000000;

	always_comb
	begin
		rd_mux = '0;
		if (in_map)
		begin
			case (raddr)
				mhc_pkg::ADDR_CTRL:     rd_mux[1:0] = ctrl_q;
				mhc_pkg::ADDR_INTERVAL: rd_mux = hm_word(interval_q);
				mhc_pkg::ADDR_RUN:      rd_mux = hm_word(run_val);
				mhc_pkg::ADDR_TOGO:     rd_mux = hm_word(togo_val);
				mhc_pkg::ADDR_STATUS:   rd_mux[mhc_pkg::EV_W-1:0] = status_q;
				mhc_pkg::ADDR_MASK:     rd_mux[mhc_pkg::EV_W-1:0] = mask_q;
				mhc_pkg::ADDR_PINS:
				begin
					rd_mux[mhc_pkg::PIN_MON]   = mon;
					rd_mux[mhc_pkg::PIN_ALARM] = alarm_q;
				end
				default:                rd_mux = '0;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// bus slave flops: zero wait state, always okay

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			rdata_q   <= 32'h00000000;
			hready_q  <= 1'b1;
		end
		else if (ce)
		begin
			wr_pend_q <= addr_ok && hwrite && in_map;
			wr_addr_q <= raddr;
			rdata_q   <= (addr_ok && !hwrite) ? rd_mux : 32'h00000000;
			hready_q  <= 1'b1;
		end
	end

	assign hrdata    = rdata_q;
	assign hreadyout = hready_q;
	assign hresp     = 1'b0;

	//////////////////////////////////////////////////////////////////////////
	// configuration and status flops

	// flops on hresetn stand in for the always-on retention domain
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_q     <= mhc_pkg::CTRL_RESET;
			interval_q <= mhc_pkg::HM_ZERO; // RULE10
			mask_q     <= mhc_pkg::MASK_RESET;
			status_q   <= '0;
		end
		else if (ce)
		begin
			if (wr_ctrl)
				ctrl_q <= hwdata[1:0]; // RULE5 RULE11
			if (wr_intv)
				interval_q <= intv_wr; // RULE6 RULE11
			if (wr_mask)
				mask_q <= hwdata[mhc_pkg::EV_W-1:0];
			status_q <= status_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// pin history, alarm and interrupt outputs

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			restart_prev_q <= 1'b0;
			clear_prev_q   <= 1'b0;
			run_sat_prev_q <= 1'b0;
			alarm_q        <= 1'b0;
			irq            <= 1'b0;
		end
		else if (ce)
		begin
			restart_prev_q <= pins.interval_restart;
			clear_prev_q   <= pins.full_clear;
			run_sat_prev_q <= run_sat;
			alarm_q        <= alarm_d; // RULE4
			irq            <= |(status_d & mask_q);
		end
	end

	assign alarm_output = alarm_q;
endmodule
